// ---- include/rpc_params.svh ----
// rpc_params.svh: offsets, field positions, reset values and cause patterns
// assumes byte addresses on a 32-bit AXI4-Lite port, one register per word
// Operation
// - a status read returns the four cause bits, then clears them
// - status reads and watchdog control writes share one address
// - bit 7 set by power-on, cleared by watchdog time-out, stop recovery, read
// - bit 6 set by stop recovery, cleared by power-on, active time-out, read
// - bit 5 set by time-out, cleared by power-on, pin recovery, read
// - bit 4 set by reset pin, cleared by power-on, stop recovery, read
// - bit 0 follows the low-supply comparator while brown-out is active, reads 0 otherwise, never latched
// - power-on gives 1000, reset pin gives 0001, watchdog reset outside stop gives 0010
// - debugger reset and debug pin low in stop both give 1000
// - pin stop recovery gives 0100, watchdog stop recovery gives 0110
// - stop powers down all but brown-out, op-amp and watchdog
// - stop halts oscillators, clock, cpu; crystal pins return to gpio
// - in stop watchdog oscillator and logic run when enabled
// - brown-out runs in stop per option; op-amp per power gate
// - halt stops only the cpu; clocks and enabled peripherals run
// - halt ends on interrupt, time-out, power-on, brown-out, reset pin
// - power gate register is reset by power-on only
// - a one in a power gate bit disables its block
// - op-amp disable resets to one; cleared, op-amp runs even in stop
// - brown-out active only when gate bit and always-on option enable it
// - gate bit disables its block whatever the block's own enables say
`ifndef RPC_PARAMS_SVH
`define RPC_PARAMS_SVH
`define RPC_ADDR_PWR_GATE 12'hF80
`define RPC_ADDR_STATUS 12'hFF0
`define RPC_PG_RESET 8'h80
`define RPC_POS_OPAMP 7
`define RPC_POS_BROWNOUT 4
`define RPC_POS_TEMP 3
`define RPC_POS_ADC 2
`define RPC_POS_COMP 1
`define RPC_CAUSE_POR 4'h8
`define RPC_CAUSE_EXT 4'h1
`define RPC_CAUSE_WDT 4'h2
`define RPC_CAUSE_SMR_GPIO 4'h4
`define RPC_CAUSE_SMR_WDT 4'h6
`define RPC_RESP_OKAY 2'h0
`define RPC_RESP_DECERR 2'h3
`endif

// ---- include/rpc_pkg.sv ----
// rpc_pkg: types shared by the reset cause and power control files
// assumes nothing of its surroundings
package rpc_pkg;
    typedef enum logic [1:0] {
        mode_active = 2'b00,
        mode_halt = 2'b01,
        mode_stop = 2'b10
    } rpc_mode_t;
    // cause bits 7..4 of the status byte
    typedef logic [3:0] rpc_cause_t;
endpackage : rpc_pkg

// ---- hdl/rpc_sync.sv ----
// rpc_sync: two-flop synchroniser for pins from outside the clock domain
// assumes aclk always runs; reset value is a parameter
`timescale 1ns/1ps
module rpc_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input logic aclk,
    input logic aresetn,
    input logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_r <= INIT;
            sync_r <= INIT;
        end else begin
            meta_r <= din;
            sync_r <= meta_r;
        end
    end

    assign dout = sync_r;
endmodule : rpc_sync

// ---- hdl/rpc_cause_latch.sv ----
// rpc_cause_latch: sticky reset and recovery cause bits 7..4
// assumes one-cycle event pulses on aclk; aresetn is power-on reset
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_cause_latch (
    input logic aclk,
    input logic aresetn,
    input logic in_stop,
    input logic rd_clear,
    input logic ev_por_like,
    input logic ev_ext_rst,
    input logic ev_wdt_rst,
    input logic ev_wdt_timeout,
    input logic ev_smr_gpio,
    output rpc_pkg::rpc_cause_t cause
);
    import rpc_pkg::*;

    rpc_cause_t cause_r;
    rpc_cause_t cause_nxt;

    // clear first, then events, so a set in the read cycle survives
    always_comb begin
        cause_nxt = cause_r;
        if (rd_clear) begin
            cause_nxt = 4'h0;
        end
        if (ev_smr_gpio) begin
            cause_nxt = `RPC_CAUSE_SMR_GPIO;
        end
        if (ev_wdt_timeout) begin
            if (in_stop) begin
                cause_nxt = `RPC_CAUSE_SMR_WDT;
            end else begin
                cause_nxt[3] = 1'b0;
                cause_nxt[2] = 1'b0;
                cause_nxt[1] = 1'b1;
            end
        end
        if (ev_wdt_rst) begin
            cause_nxt = `RPC_CAUSE_WDT;
        end
        if (ev_ext_rst) begin
            cause_nxt = `RPC_CAUSE_EXT;
        end
        if (ev_por_like) begin
            cause_nxt = `RPC_CAUSE_POR;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cause_r <= `RPC_CAUSE_POR;
        end else begin
            cause_r <= cause_nxt;
        end
    end

    assign cause = cause_r;
endmodule : rpc_cause_latch

// ---- hdl/rpc_top.sv ----
// rpc_top: reset cause status, peripheral power gate and power modes
// assumes aclk keeps running in stop; event inputs are one-cycle pulses on aclk
// from the reset sequencer, watchdog, gpio and cpu; aresetn is power-on reset
`timescale 1ns/1ps
`include "rpc_params.svh"
module rpc_top #(
    parameter int ADDR_W = 12
) (
    input logic aclk,
    input logic aresetn,
    input logic [ADDR_W-1:0] s_axi_awaddr,
    input logic [2:0] s_axi_awprot,
    input logic s_axi_awvalid,
    output logic s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0] s_axi_wstrb,
    input logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input logic s_axi_bready,
    input logic [ADDR_W-1:0] s_axi_araddr,
    input logic [2:0] s_axi_arprot,
    input logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input logic s_axi_rready,
    input logic halt_instr,
    input logic stop_instr,
    input logic irq_req,
    input logic ext_reset_evt,
    input logic wdt_timeout,
    input logic wdt_reset_evt,
    input logic dbg_reset_evt,
    input logic brownout_reset_evt,
    input logic smr_gpio_evt,
    input logic debug_pin,
    input logic low_supply_cmp,
    input logic brownout_always_on_option,
    input logic brownout_stop_option,
    input logic wdt_osc_enable,
    input logic wdt_enable,
    input logic xtal_enable,
    input logic temp_enable,
    input logic adc_enable,
    input logic comp_enable,
    output rpc_pkg::rpc_mode_t power_mode,
    output logic cpu_run,
    output logic sys_clk_run,
    output logic osc_run,
    output logic crystal_pins_gpio,
    output logic wdt_osc_run,
    output logic wdt_logic_run,
    output logic brownout_run,
    output logic opamp_run,
    output logic temp_clk_en,
    output logic adc_clk_en,
    output logic comp_clk_en,
    output logic wdt_ctrl_wr,
    output logic [7:0] wdt_ctrl_data
);
    import rpc_pkg::*;

    // ---------------- pin synchronisers ----------------
    logic low_supply_s;
    logic debug_pin_s;

    rpc_sync #(
        .WIDTH(2),
        .INIT(2'h2)
    ) u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .din({debug_pin, low_supply_cmp}),
        .dout({debug_pin_s, low_supply_s})
    );

    // ---------------- power mode state ----------------
    rpc_mode_t mode_r;
    rpc_mode_t mode_nxt;
    logic in_stop;
    logic dbg_pin_stop_rst;
    logic sys_reset_any;
    logic halt_exit;
    logic stop_exit;

    assign in_stop = (mode_r == mode_stop);
    // debug pin held low while stopped forces a system reset
    assign dbg_pin_stop_rst = in_stop & ~debug_pin_s;
    assign sys_reset_any = ext_reset_evt | wdt_reset_evt | dbg_reset_evt
                         | brownout_reset_evt | dbg_pin_stop_rst;
    assign halt_exit = irq_req | wdt_timeout | wdt_reset_evt
                     | brownout_reset_evt | ext_reset_evt | dbg_reset_evt;
    assign stop_exit = smr_gpio_evt | wdt_timeout | sys_reset_any;

    always_comb begin
        mode_nxt = mode_r;
        case (mode_r)
            mode_active: begin
                if (sys_reset_any) begin
                    mode_nxt = mode_active;
                end else if (stop_instr) begin
                    mode_nxt = mode_stop;
                end else if (halt_instr) begin
                    mode_nxt = mode_halt;
                end
            end
            mode_halt: begin
                if (halt_exit) begin
                    mode_nxt = mode_active;
                end
            end
            mode_stop: begin
                if (stop_exit) begin
                    mode_nxt = mode_active;
                end
            end
            default: begin
                mode_nxt = mode_active;
            end
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r <= mode_active;
        end else begin
            mode_r <= mode_nxt;
        end
    end

    // ---------------- status cause bits ----------------
    logic status_rd_clear;
    rpc_cause_t cause;
    logic [7:0] status_byte;
    logic brownout_nxt;

    rpc_cause_latch u_cause (
        .aclk(aclk),
        .aresetn(aresetn),
        .in_stop(in_stop),
        .rd_clear(status_rd_clear),
        .ev_por_like(dbg_reset_evt | dbg_pin_stop_rst | brownout_reset_evt),
        .ev_ext_rst(ext_reset_evt),
        .ev_wdt_rst(wdt_reset_evt & ~in_stop),
        .ev_wdt_timeout(wdt_timeout),
        .ev_smr_gpio(smr_gpio_evt & in_stop),
        .cause(cause)
    );

    // ---------------- AXI4-Lite write path ----------------
    logic aw_full_r;
    logic aw_full_nxt;
    logic w_full_r;
    logic w_full_nxt;
    logic [ADDR_W-1:0] waddr_r;
    logic [ADDR_W-1:0] waddr_nxt;
    logic [7:0] wbyte_r;
    logic [7:0] wbyte_nxt;
    logic wlane_r;
    logic wlane_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;
    logic wr_fire;
    logic [7:0] pg_r;
    logic [7:0] pg_nxt;
    logic wdt_wr_r;
    logic wdt_wr_nxt;
    logic [7:0] wdt_data_r;
    logic [7:0] wdt_data_nxt;

    assign wr_fire = aw_full_r & w_full_r & ~bvalid_r;

    always_comb begin
        aw_full_nxt = aw_full_r;
        w_full_nxt = w_full_r;
        waddr_nxt = waddr_r;
        wbyte_nxt = wbyte_r;
        wlane_nxt = wlane_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        pg_nxt = pg_r;
        wdt_wr_nxt = 1'b0;
        wdt_data_nxt = wdt_data_r;
        if (s_axi_awvalid && awready_r) begin
            aw_full_nxt = 1'b1;
            waddr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_full_nxt = 1'b1;
            wbyte_nxt = s_axi_wdata[7:0];
            wlane_nxt = s_axi_wstrb[0];
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_full_nxt = 1'b0;
            w_full_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = `RPC_RESP_OKAY;
            if (waddr_r == `RPC_ADDR_PWR_GATE) begin
                if (wlane_r) begin
                    pg_nxt = wbyte_r;
                end
            end else if (waddr_r == `RPC_ADDR_STATUS) begin
                // writes here reach the watchdog control, not the status
                if (wlane_r) begin
                    wdt_wr_nxt = 1'b1;
                    wdt_data_nxt = wbyte_r;
                end
            end else begin
                bresp_nxt = `RPC_RESP_DECERR;
            end
        end
        awready_nxt = ~aw_full_nxt;
        wready_nxt = ~w_full_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            waddr_r <= '0;
            wbyte_r <= 8'h00;
            wlane_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            bvalid_r <= 1'b0;
            bresp_r <= `RPC_RESP_OKAY;
            pg_r <= `RPC_PG_RESET;
            wdt_wr_r <= 1'b0;
            wdt_data_r <= 8'h00;
        end else begin
            aw_full_r <= aw_full_nxt;
            w_full_r <= w_full_nxt;
            waddr_r <= waddr_nxt;
            wbyte_r <= wbyte_nxt;
            wlane_r <= wlane_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            // only aresetn reloads the gate; system resets leave it alone
            pg_r <= pg_nxt;
            wdt_wr_r <= wdt_wr_nxt;
            wdt_data_r <= wdt_data_nxt;
        end
    end

    // ---------------- AXI4-Lite read path ----------------
    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [7:0] rbyte_r;
    logic [7:0] rbyte_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;
    logic rd_take;

    assign rd_take = s_axi_arvalid & arready_r;
    assign status_rd_clear = rd_take & (s_axi_araddr == `RPC_ADDR_STATUS);
    assign status_byte = {cause, 3'b000, low_supply_s & brownout_nxt};

    always_comb begin
        rvalid_nxt = rvalid_r;
        rbyte_nxt = rbyte_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (rd_take) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = `RPC_RESP_OKAY;
            if (s_axi_araddr == `RPC_ADDR_PWR_GATE) begin
                rbyte_nxt = pg_r;
            end else if (s_axi_araddr == `RPC_ADDR_STATUS) begin
                rbyte_nxt = status_byte;
            end else begin
                rbyte_nxt = 8'h00;
                rresp_nxt = `RPC_RESP_DECERR;
            end
        end
        arready_nxt = ~rvalid_nxt;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rbyte_r <= 8'h00;
            rresp_r <= `RPC_RESP_OKAY;
        end else begin
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rbyte_r <= rbyte_nxt;
            rresp_r <= rresp_nxt;
        end
    end

    // ---------------- power and clock enables ----------------
    logic cpu_nxt;
    logic sysclk_nxt;
    logic osc_nxt;
    logic xpins_nxt;
    logic wdt_osc_nxt;
    logic wdt_logic_nxt;
    logic opamp_nxt;
    logic temp_nxt;
    logic adc_nxt;
    logic comp_nxt;
    logic en_r [0:10];

    always_comb begin
        cpu_nxt = (mode_r == mode_active);
        sysclk_nxt = ~in_stop;
        osc_nxt = ~in_stop;
        xpins_nxt = in_stop | ~xtal_enable;
        wdt_osc_nxt = wdt_osc_enable;
        wdt_logic_nxt = wdt_enable;
        brownout_nxt = ~pg_r[`RPC_POS_BROWNOUT] & brownout_always_on_option
                     & (~in_stop | brownout_stop_option);
        opamp_nxt = ~pg_r[`RPC_POS_OPAMP];
        // gate bit wins over the block's own enable; stop idles the rest
        temp_nxt = temp_enable & ~pg_r[`RPC_POS_TEMP] & ~in_stop;
        adc_nxt = adc_enable & ~pg_r[`RPC_POS_ADC] & ~in_stop;
        comp_nxt = comp_enable & ~pg_r[`RPC_POS_COMP] & ~in_stop;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 11; i++) begin
                en_r[i] <= 1'b0;
            end
        end else begin
            en_r[0] <= cpu_nxt;
            en_r[1] <= sysclk_nxt;
            en_r[2] <= osc_nxt;
            en_r[3] <= xpins_nxt;
            en_r[4] <= wdt_osc_nxt;
            en_r[5] <= wdt_logic_nxt;
            en_r[6] <= brownout_nxt;
            en_r[7] <= opamp_nxt;
            en_r[8] <= temp_nxt;
            en_r[9] <= adc_nxt;
            en_r[10] <= comp_nxt;
        end
    end

    // ---------------- outputs ----------------
    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = {24'h000000, rbyte_r};
    assign s_axi_rresp = rresp_r;
    assign power_mode = mode_r;
    assign cpu_run = en_r[0];
    assign sys_clk_run = en_r[1];
    assign osc_run = en_r[2];
    assign crystal_pins_gpio = en_r[3];
    assign wdt_osc_run = en_r[4];
    assign wdt_logic_run = en_r[5];
    assign brownout_run = en_r[6];
    assign opamp_run = en_r[7];
    assign temp_clk_en = en_r[8];
    assign adc_clk_en = en_r[9];
    assign comp_clk_en = en_r[10];
    assign wdt_ctrl_wr = wdt_wr_r;
    assign wdt_ctrl_data = wdt_data_r;
endmodule : rpc_top

// ---- testbench/rpc_top_sva.sv ----
// rpc_top_sva: power mode, run enable and watchdog alias checks for rpc_top
// assumes it is bound onto rpc_top; aresetn is the synchronous power-on reset
`timescale 1ns/1ps
module rpc_top_sva (
    input logic aclk,
    input logic aresetn,
    input logic s_axi_bvalid,
    input logic stop_instr,
    input logic halt_instr,
    input logic irq_req,
    input logic wdt_timeout,
    input logic smr_gpio_evt,
    input logic ext_reset_evt,
    input logic wdt_reset_evt,
    input logic dbg_reset_evt,
    input logic brownout_reset_evt,
    input logic wdt_enable,
    input logic wdt_osc_enable,
    input logic brownout_always_on_option,
    input logic brownout_stop_option,
    input rpc_pkg::rpc_mode_t power_mode,
    input logic cpu_run,
    input logic sys_clk_run,
    input logic osc_run,
    input logic crystal_pins_gpio,
    input logic wdt_osc_run,
    input logic wdt_logic_run,
    input logic brownout_run,
    input logic temp_clk_en,
    input logic adc_clk_en,
    input logic comp_clk_en,
    input logic wdt_ctrl_wr
);
    import rpc_pkg::*;
    logic sysrst;
    assign sysrst = ext_reset_evt | wdt_reset_evt | dbg_reset_evt | brownout_reset_evt;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_stop_entry: assert property (power_mode == mode_active && stop_instr && !sysrst |=> power_mode == mode_stop)
        else $error("stop instruction did not enter stop");
    a_stop_halts: assert property (power_mode == mode_stop |=> !cpu_run && !sys_clk_run && !osc_run && crystal_pins_gpio)
        else $error("clock or cpu still running in stop");
    a_stop_idle: assert property (power_mode == mode_stop |=> !(temp_clk_en || adc_clk_en || comp_clk_en))
        else $error("peripheral clock running in stop");
    a_stop_wdt: assert property (power_mode == mode_stop |=> wdt_logic_run == $past(wdt_enable)
        && wdt_osc_run == $past(wdt_osc_enable)) else $error("watchdog run state wrong in stop");
    a_stop_brownout: assert property (power_mode == mode_stop && !brownout_stop_option |=> !brownout_run)
        else $error("brownout running in stop without option");
    a_bo_option: assert property (!brownout_always_on_option |=> !brownout_run)
        else $error("brownout running with option off");
    a_halt_run: assert property (power_mode == mode_halt |=> !cpu_run && sys_clk_run && osc_run)
        else $error("halt run flags wrong");
    a_halt_wake: assert property (power_mode == mode_halt && (irq_req || wdt_timeout || sysrst)
        |=> power_mode == mode_active) else $error("halt not ended by wake event");
    a_gpio_wake: assert property (power_mode == mode_stop && smr_gpio_evt |=> power_mode == mode_active)
        else $error("gpio transition did not end stop");
    a_wdt_pulse: assert property (wdt_ctrl_wr |-> s_axi_bvalid ##1 !wdt_ctrl_wr)
        else $error("watchdog control pulse not tied to a write");
    c_stop_wake: cover property (power_mode == mode_stop ##1 power_mode == mode_active);
    c_halt: cover property (power_mode == mode_active && halt_instr);
    c_wdt_wr: cover property (wdt_ctrl_wr);
endmodule : rpc_top_sva

bind rpc_top rpc_top_sva rpc_top_sva_i (.aclk, .aresetn, .s_axi_bvalid, .stop_instr, .halt_instr, .irq_req,
    .wdt_timeout, .smr_gpio_evt, .ext_reset_evt, .wdt_reset_evt, .dbg_reset_evt, .brownout_reset_evt, .wdt_enable,
    .wdt_osc_enable, .brownout_always_on_option, .brownout_stop_option, .power_mode, .cpu_run, .sys_clk_run,
    .osc_run, .crystal_pins_gpio, .wdt_osc_run, .wdt_logic_run, .brownout_run, .temp_clk_en, .adc_clk_en,
    .comp_clk_en, .wdt_ctrl_wr);

// ---- testbench/test_rpc_top.sv ----
// test_rpc_top: directed bench for status causes, power gate and power modes
// assumes rpc_top with its checker bound; acts as AXI4-Lite master at 20 MHz
`timescale 1ns/1ps
module test_rpc_top;
    import rpc_pkg::*;
    localparam logic [11:0] A_GATE = 12'hF80;
    localparam logic [11:0] A_STAT = 12'hFF0;
    localparam logic [8:0] E_EXT = 9'h001, E_WRST = 9'h002, E_DBG = 9'h004, E_BO = 9'h008, E_WTO = 9'h010;
    localparam logic [8:0] E_GPIO = 9'h020, E_STOP = 9'h040, E_HALT = 9'h080, E_IRQ = 9'h100;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic debug_pin = 1'h1, low_supply_cmp = 1'h0;
    logic [8:0] ev = '0;
    logic [7:0] cfg = 8'hFF;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wdt_ctrl_wr;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata;
    logic [7:0] wdt_ctrl_data, d, wdt_seen = 8'h00;
    rpc_mode_t power_mode;
    logic cpu_run, sys_clk_run, osc_run, crystal_pins_gpio, wdt_osc_run, wdt_logic_run, brownout_run, opamp_run;
    logic temp_clk_en, adc_clk_en, comp_clk_en;
    logic [6:0] runs;
    int n_mismatch = 0, tests_run = 0;
    assign runs = {cpu_run, sys_clk_run, osc_run, crystal_pins_gpio, opamp_run, temp_clk_en, wdt_logic_run};
    always #25 aclk = ~aclk;
    always @(posedge aclk) if (wdt_ctrl_wr) wdt_seen <= wdt_ctrl_data;
    rpc_top rpc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .halt_instr(ev[7]), .stop_instr(ev[6]), .irq_req(ev[8]),
        .ext_reset_evt(ev[0]), .wdt_timeout(ev[4]), .wdt_reset_evt(ev[1]), .dbg_reset_evt(ev[2]),
        .brownout_reset_evt(ev[3]), .smr_gpio_evt(ev[5]), .debug_pin, .low_supply_cmp,
        .brownout_always_on_option(cfg[7]), .brownout_stop_option(cfg[6]), .wdt_osc_enable(cfg[5]),
        .wdt_enable(cfg[4]), .xtal_enable(cfg[3]), .temp_enable(cfg[2]), .adc_enable(cfg[1]), .comp_enable(cfg[0]),
        .power_mode, .cpu_run, .sys_clk_run, .osc_run, .crystal_pins_gpio, .wdt_osc_run, .wdt_logic_run,
        .brownout_run, .opamp_run, .temp_clk_en, .adc_clk_en, .comp_clk_en, .wdt_ctrl_wr, .wdt_ctrl_data);

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk

    task automatic hang(input logic ok);
        if (!ok) begin
            chk("bus answer", 1'h0, 1'h1);
            stop_test();
        end
    endtask : hang

    task automatic cyc(input int n);
        repeat (n) @(posedge aclk);
    endtask : cyc

    task automatic pu(input logic [8:0] m);
        ev <= m;
        @(posedge aclk);
        ev <= '0;
        cyc(2);
    endtask : pu

    task automatic wr(input logic [11:0] a, input logic [7:0] v, output logic [1:0] resp);
        int n = 0;
        logic ad = 1'h0;
        logic wd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
            ad |= s_axi_awready;
            wd |= s_axi_wready;
            if (ad) s_axi_awvalid <= 1'h0;
            if (wd) s_axi_wvalid <= 1'h0;
        end while (!s_axi_bvalid && n < 40);
        s_axi_bready <= 1'h0;
        resp = s_axi_bresp;
        hang(s_axi_bvalid);
        @(posedge aclk);
    endtask : wr

    // m pulses at the edge that takes the address
    task automatic rd(input logic [11:0] a, input logic [8:0] m, output logic [7:0] v, output logic [1:0] resp);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        ev <= m;
        do begin
            @(posedge aclk);
            n++;
            ev <= '0;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (!s_axi_rvalid && n < 40);
        s_axi_rready <= 1'h0;
        v = s_axi_rdata[7:0];
        resp = s_axi_rresp;
        hang(s_axi_rvalid);
        @(posedge aclk);
    endtask : rd

    task automatic rs(input string nm, input logic [11:0] a, input logic [7:0] e);
        logic [7:0] v;
        logic [1:0] rr;
        rd(a, '0, v, rr);
        chk(nm, {rr, v}, {2'h0, e});
    endtask : rs

    task automatic t_bus();
        rs("status", A_STAT, 8'h80);
        rs("status", A_STAT, 8'h00);
        rs("gate", A_GATE, 8'h80);
        chk("opamp", opamp_run, 1'h0);
        wr(A_STAT, 8'h5A, r);
        chk("wdt byte", {r, wdt_seen}, 10'h05A);
        rs("status", A_STAT, 8'h00);
        rd(12'h100, '0, d, r);
        chk("unmapped rd", {r, d}, 10'h300);
        wr(12'h100, 8'h00, r);
        chk("unmapped wr", r, 2'h3);
    endtask : t_bus

    task automatic t_gate();
        wr(A_GATE, 8'h00, r);
        cyc(2);
        chk("enables", {opamp_run, brownout_run, temp_clk_en, adc_clk_en, comp_clk_en}, 5'h1F);
        wr(A_GATE, 8'h1E, r);
        cyc(2);
        chk("enables", {opamp_run, brownout_run, temp_clk_en, adc_clk_en, comp_clk_en}, 5'h10);
        rs("gate", A_GATE, 8'h1E);
        wr(A_GATE, 8'h00, r);
        cfg[7] <= 1'h0;
        cyc(2);
        chk("brownout", brownout_run, 1'h0);
        cfg[7] <= 1'h1;
        cyc(2);
        chk("brownout", brownout_run, 1'h1);
    endtask : t_gate

    task automatic t_cause();
        logic [8:0] a[6] = '{E_EXT, E_WRST, E_DBG, E_BO, E_EXT, E_DBG};
        logic [8:0] b[6] = '{9'h0, 9'h0, 9'h0, 9'h0, E_WTO, E_WTO};
        logic [7:0] e[6] = '{8'h10, 8'h20, 8'h80, 8'h80, 8'h30, 8'h20};
        for (int i = 0; i < 6; i++) begin
            pu(a[i]);
            pu(b[i]);
            rs("status", A_STAT, e[i]);
        end
    endtask : t_cause

    task automatic t_stop();
        pu(E_STOP);
        chk("stop runs", {power_mode, runs}, {mode_stop, 7'h0D});
        pu(E_GPIO);
        rs("status", A_STAT, 8'h40);
        pu(E_STOP);
        pu(E_GPIO);
        pu(E_WTO);
        rs("status", A_STAT, 8'h20);
        cfg <= 8'hAF;
        pu(E_STOP);
        chk("stop wdt bo", {wdt_osc_run, wdt_logic_run, brownout_run}, 3'h4);
        pu(E_WTO);
        cfg <= 8'hFF;
        rs("status", A_STAT, 8'h60);
        pu(E_STOP);
        pu(E_EXT);
        rs("status", A_STAT, 8'h10);
        pu(E_STOP);
        debug_pin <= 1'h0;
        for (int i = 0; i < 10 && power_mode !== mode_active; i++) @(posedge aclk);
        debug_pin <= 1'h1;
        cyc(3);
        chk("mode", power_mode, mode_active);
        rs("status", A_STAT, 8'h80);
        rs("gate", A_GATE, 8'h00);
    endtask : t_stop

    task automatic t_halt();
        logic [8:0] w[3] = '{E_IRQ, E_WTO, E_EXT};
        logic [7:0] e[3] = '{8'h00, 8'h20, 8'h10};
        for (int i = 0; i < 3; i++) begin
            pu(E_HALT);
            chk("halt runs", {power_mode, runs}, {mode_halt, 7'h37});
            pu(w[i]);
            chk("mode", power_mode, mode_active);
            rs("status", A_STAT, e[i]);
        end
    endtask : t_halt

    task automatic t_lvd();
        rd(A_STAT, E_EXT, d, r);
        chk("status", d, 8'h00);
        rs("status", A_STAT, 8'h10);
        low_supply_cmp <= 1'h1;
        cyc(4);
        rs("status", A_STAT, 8'h01);
        rs("status", A_STAT, 8'h01);
        wr(A_GATE, 8'h10, r);
        cyc(4);
        rs("status", A_STAT, 8'h00);
        wr(A_GATE, 8'h00, r);
        low_supply_cmp <= 1'h0;
        cyc(4);
        rs("status", A_STAT, 8'h00);
    endtask : t_lvd

    initial begin
        cyc(4);
        aresetn <= 1'h1;
        cyc(1);
        t_bus();
        t_gate();
        t_cause();
        t_stop();
        t_halt();
        t_lvd();
        stop_test();
    end
endmodule : test_rpc_top
